// file: design/power_mode_sequencer.sv
// Power mode sequencer: Active, Sleep and Deep Sleep with wake timing,
// supply hold-off and brown-out reset.
// Assumes all inputs are synchronous to mclk_in; mclk_in is the always-on
// clock, high-speed logic is gated via hf_clk_en.
`timescale 1ns/1ns
`include "power_mode_params.svh"

// Summary of operation
// - Three modes only; all transitions handled by this sequencer.
// - Active keeps every clock enable on.
// - Sleep gates processor, flash, SRAM clocks; peripherals stay clocked.
// - Wake from Sleep restores processor clock next cycle, no delay.
// - Deep Sleep turns off high-speed clock and its logic.
// - Deep Sleep wake takes 35 us to Active.
// - After power-on, mode entry waits for supply-good.
// - Brown-out forces a system reset.
// - Wake-up detector stays powered in Deep Sleep; processor power removed.
// - Reset cause register survives the reset it records.
module power_mode_sequencer
#(
   parameter int WAKE_CYCLES = `DS_WAKE_CYCLES,
   parameter int IRQ_COUNT   = 8
)
(
   input  wire logic                          mclk_in,
   input  wire logic                          nrst_in,
   input  wire logic                          supply_good_in,
   input  wire logic                          brownout_in,
   input  wire logic                          sleep_req_in,
   input  wire logic                          deep_req_in,
   input  wire logic [IRQ_COUNT-1:0]          irq_in,
   input  wire logic [IRQ_COUNT-1:0]          irq_enable_in,
   input  wire logic                          cause_clear_in,
   output logic                               sys_rst_n_out,
   output power_mode_pkg::pm_mode_t           mode_out,
   output power_mode_pkg::gate_ctrl_t         gate_out,
   output logic                               wakeup_detector_en_out,
   output logic                               wake_event_out,
   output logic [`CAUSE_WIDTH-1:0]            reset_cause_out
);

   localparam int CW = $clog2(WAKE_CYCLES + 1);

   // ----------------------------------------
   // State
   // ----------------------------------------
   power_mode_pkg::pm_state_t  state;
   power_mode_pkg::pm_state_t  next_state;
   logic [CW-1:0]              wake_cnt;
   logic [CW-1:0]              next_wake_cnt;
   power_mode_pkg::pm_mode_t   next_mode;
   power_mode_pkg::gate_ctrl_t next_gate;
   logic                       next_det_en;
   logic                       next_rst_n;
   logic                       next_wake_event;
   logic [`CAUSE_WIDTH-1:0]    next_cause;
   logic                       wake;

   // ----------------------------------------
   // Wake detection
   // ----------------------------------------
   assign wake = |(irq_in & irq_enable_in);

   always_comb
   begin
      next_state      = state;
      next_wake_cnt   = wake_cnt;
      next_wake_event = 1'b0;
      if (brownout_in)
      begin
         next_state = power_mode_pkg::ST_HOLD;
      end
      else
      begin
         unique case (state)
            power_mode_pkg::ST_HOLD:
            begin
               if (supply_good_in)
               begin
                  next_state = power_mode_pkg::ST_ACT;
               end
            end
            power_mode_pkg::ST_ACT:
            begin
               // Deep request wins when both are raised
               if (deep_req_in)
               begin
                  next_state = power_mode_pkg::ST_DEEP;
               end
               else if (sleep_req_in)
               begin
                  next_state = power_mode_pkg::ST_SLEEP;
               end
            end
            power_mode_pkg::ST_SLEEP:
            begin
               if (wake)
               begin
                  next_state      = power_mode_pkg::ST_ACT;
                  next_wake_event = 1'b1;
               end
            end
            power_mode_pkg::ST_DEEP:
            begin
               if (wake)
               begin
                  next_state      = power_mode_pkg::ST_WAKE;
                  next_wake_cnt   = CW'(WAKE_CYCLES - 1);
                  next_wake_event = 1'b1;
               end
            end
            power_mode_pkg::ST_WAKE:
            begin
               // Counter covers regulator and oscillator restart
               if (wake_cnt == '0)
               begin
                  next_state = power_mode_pkg::ST_ACT;
               end
               else
               begin
                  next_wake_cnt = wake_cnt - 1'b1;
               end
            end
            default:
            begin
               next_state = power_mode_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs decoded from the next state
   // ----------------------------------------
   always_comb
   begin
      next_gate   = '0;
      next_mode   = power_mode_pkg::MODE_ACTIVE;
      next_det_en = 1'b0;
      next_rst_n  = 1'b1;
      unique case (next_state)
         power_mode_pkg::ST_HOLD:
         begin
            next_rst_n = 1'b0;
         end
         power_mode_pkg::ST_ACT:
         begin
            next_gate = '1;
         end
         power_mode_pkg::ST_SLEEP:
         begin
            next_mode                = power_mode_pkg::MODE_SLEEP;
            next_gate.periph_clk_en  = 1'b1;
            next_gate.hf_clk_en      = 1'b1;
            next_gate.cpu_pwr_en     = 1'b1;
         end
         power_mode_pkg::ST_DEEP:
         begin
            // All high-speed enables and processor power off
            next_mode   = power_mode_pkg::MODE_DEEP;
            next_det_en = 1'b1;
         end
         power_mode_pkg::ST_WAKE:
         begin
            next_mode   = power_mode_pkg::MODE_DEEP;
            next_det_en = 1'b1;
            next_gate.hf_clk_en  = 1'b1;
            next_gate.cpu_pwr_en = 1'b1;
         end
         default:
         begin
            next_rst_n = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Reset cause, sticky through brown-out
   // ----------------------------------------
   always_comb
   begin
      next_cause = reset_cause_out;
      if (cause_clear_in)
      begin
         next_cause = '0;
      end
      // Set wins over software clear
      if (brownout_in)
      begin
         next_cause[`CAUSE_BOD_BIT] = 1'b1;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         state                  <= power_mode_pkg::ST_HOLD;
         wake_cnt               <= '0;
         mode_out               <= power_mode_pkg::MODE_ACTIVE;
         gate_out               <= '0;
         wakeup_detector_en_out <= 1'b0;
         sys_rst_n_out          <= 1'b0;
         wake_event_out         <= 1'b0;
         reset_cause_out        <= `CAUSE_RESET_VAL;
      end
      else
      begin
         state                  <= next_state;
         wake_cnt               <= next_wake_cnt;
         mode_out               <= next_mode;
         gate_out               <= next_gate;
         wakeup_detector_en_out <= next_det_en;
         sys_rst_n_out          <= next_rst_n;
         wake_event_out         <= next_wake_event;
         reset_cause_out        <= next_cause;
      end
   end

endmodule

// file: design/power_mode_params.svh
// Timing counts and reset-cause field positions for the power mode sequencer.
// Assumes inclusion by the package, the sequencer module and the property checker.
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS     20
`define DS_WAKE_TIME_US   35
// Longest time rounds down to whole cycles
`define DS_WAKE_CYCLES    ((`DS_WAKE_TIME_US * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset cause bits
// ----------------------------------------
`define CAUSE_POR_BIT     0
`define CAUSE_BOD_BIT     1
`define CAUSE_WIDTH       2
`define CAUSE_RESET_VAL   2'h1

`endif

// file: design/power_mode_pkg.sv
// Types shared by the power mode sequencer and its bench.
// Assumes the params header sits in the same folder.
`include "power_mode_params.svh"

package power_mode_pkg;

   typedef enum logic [2:0]
   {
      ST_HOLD  = 3'b000,
      ST_ACT   = 3'b001,
      ST_SLEEP = 3'b010,
      ST_DEEP  = 3'b011,
      ST_WAKE  = 3'b100
   } pm_state_t;

   typedef enum logic [1:0]
   {
      MODE_ACTIVE = 2'b00,
      MODE_SLEEP  = 2'b01,
      MODE_DEEP   = 2'b10
   } pm_mode_t;

   typedef struct packed
   {
      logic cpu_clk_en;
      logic flash_clk_en;
      logic sram_clk_en;
      logic periph_clk_en;
      logic hf_clk_en;
      logic cpu_pwr_en;
   } gate_ctrl_t;

endpackage

// file: tb/power_mode_properties.sv
// Checker for the power mode sequencer, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "power_mode_params.svh"
module power_mode_properties
#(
   parameter int WAKE_CYCLES = `DS_WAKE_CYCLES,
   parameter int IRQ_COUNT   = 8
)
(
   input wire logic                       mclk_in,
   input wire logic                       nrst_in,
   input wire logic                       supply_good_in,
   input wire logic                       brownout_in,
   input wire logic [IRQ_COUNT-1:0]       irq_in,
   input wire logic [IRQ_COUNT-1:0]       irq_enable_in,
   input wire logic                       sys_rst_n_out,
   input wire power_mode_pkg::pm_mode_t   mode_out,
   input wire power_mode_pkg::gate_ctrl_t gate_out,
   input wire logic                       wakeup_detector_en_out,
   input wire logic                       wake_event_out,
   input wire logic [`CAUSE_WIDTH-1:0]    reset_cause_out
);
   int   wcnt;
   logic slp;
   logic dp;
   logic wph;
   logic wk;
   assign slp = mode_out == power_mode_pkg::MODE_SLEEP;
   assign dp  = mode_out == power_mode_pkg::MODE_DEEP;
   assign wph = dp && gate_out.hf_clk_en;
   assign wk  = |(irq_in & irq_enable_in) && !brownout_in;
   // Wake phase length; too long to unroll as a repetition
   always_ff @(posedge mclk_in)
      wcnt <= (!nrst_in || !wph) ? 0 : wcnt + 1;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_active_all_on: assert property (
      mode_out == power_mode_pkg::MODE_ACTIVE && sys_rst_n_out |-> gate_out == 6'h3F)
      else $error("active gating");
   a_sleep_gates: assert property (
      slp |-> gate_out == 6'h07) else $error("sleep gating");
   a_sleep_wake_now: assert property (
      slp && wk |=> mode_out == power_mode_pkg::MODE_ACTIVE && wake_event_out)
      else $error("sleep wake late");
   a_sleep_no_wake: assert property (
      slp && !wk && !brownout_in |=> slp) else $error("sleep left");
   a_deep_entry: assert property (
      $rose(dp) |-> gate_out == 6'h00 && wakeup_detector_en_out) else $error("deep entry");
   a_deep_wake_time: assert property (
      wph |-> ((wcnt < WAKE_CYCLES) and (wcnt == WAKE_CYCLES - 1 && !brownout_in
      |=> mode_out == power_mode_pkg::MODE_ACTIVE))) else $error("deep wake time");
   a_brownout_reset: assert property (
      brownout_in |=> !sys_rst_n_out && reset_cause_out[1]) else $error("brownout");
   a_supply_hold: assert property (
      !supply_good_in && !sys_rst_n_out |=> !sys_rst_n_out) else $error("supply hold");
   c_sleep: cover property (slp && wk);
   c_deep: cover property (wph && wcnt == WAKE_CYCLES - 1);
   c_bo: cover property (brownout_in && sys_rst_n_out);
endmodule

bind power_mode_sequencer power_mode_properties
   #(.WAKE_CYCLES(WAKE_CYCLES), .IRQ_COUNT(IRQ_COUNT)) u_props
(
   .mclk_in(mclk_in), .nrst_in(nrst_in), .supply_good_in(supply_good_in),
   .brownout_in(brownout_in), .irq_in(irq_in), .irq_enable_in(irq_enable_in),
   .sys_rst_n_out(sys_rst_n_out), .mode_out(mode_out), .gate_out(gate_out),
   .wakeup_detector_en_out(wakeup_detector_en_out), .wake_event_out(wake_event_out),
   .reset_cause_out(reset_cause_out)
);

// file: tb/power_mode_sequencer_tb.sv
// Self-checking bench for the power mode sequencer.
// Assumes the property checker is bound from its own file.
`timescale 1ns/1ns
module power_mode_sequencer_tb;
   localparam int WC = 5;
   logic                       mclk_in = 1'b0;
   logic                       nrst_in = 1'b0;
   logic                       sup     = 1'b0;
   logic                       bo      = 1'b0;
   logic                       slp     = 1'b0;
   logic                       dp      = 1'b0;
   logic                       clr     = 1'b0;
   logic [7:0]                 irq     = 8'h00;
   logic [7:0]                 en      = 8'h00;
   logic                       rst_n;
   logic                       wev;
   logic                       det;
   logic [1:0]                 cause;
   power_mode_pkg::pm_mode_t   mode;
   power_mode_pkg::gate_ctrl_t gate;
   logic [12:0]                q[$];
   int                         mismatches = 0;
   int                         checks     = 0;
   int                         k;

   always #10 mclk_in = ~mclk_in;

   power_mode_sequencer #(.WAKE_CYCLES(WC)) u_dut
   (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .supply_good_in(sup), .brownout_in(bo),
      .sleep_req_in(slp), .deep_req_in(dp), .irq_in(irq), .irq_enable_in(en),
      .cause_clear_in(clr), .sys_rst_n_out(rst_n), .mode_out(mode), .gate_out(gate),
      .wakeup_detector_en_out(det), .wake_event_out(wev), .reset_cause_out(cause)
   );

   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Note {detector, cause, reset, mode, gates, wake} for the coming edge
   task automatic e(input logic [12:0] x);
      q.push_back(x);
      @(negedge mclk_in);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge mclk_in)
   begin
      #1;
      if (q.size() > 0)
         check({det, cause, rst_n, mode, gate, wev}, q.pop_front());
   end

   initial
   begin
      k = $urandom(92);
      repeat (12) @(negedge mclk_in);
      nrst_in = 1'b1;
      e(13'h0400);
      e(13'h0400);
      sup = 1'b1;
      e(13'h067E);
      $display("test power-up done");
      for (int i = 0; i < 3; i++)
      begin
         k   = $urandom_range(7);
         slp = 1'b1;
         e(13'h068E);
         slp = 1'b0;
         irq = 8'h01 << k;
         en  = 8'($urandom) & ~irq;
         e(13'h068E);
         en  = en | irq;
         e(13'h067F);
         irq = 8'h00;
         e(13'h067E);
      end
      $display("test sleep done");
      slp = 1'b1;
      dp  = 1'b1;
      e(13'h1700);
      slp = 1'b0;
      dp  = 1'b0;
      e(13'h1700);
      irq = 8'h80;
      en  = 8'h80;
      e(13'h1707);
      irq = 8'h00;
      repeat (WC - 1) e(13'h1706);
      e(13'h067E);
      $display("test deep sleep done");
      bo = 1'b1;
      e(13'h0C00);
      sup = 1'b0;
      bo  = 1'b0;
      e(13'h0C00);
      sup = 1'b1;
      e(13'h0E7E);
      clr = 1'b1;
      e(13'h027E);
      clr = 1'b0;
      e(13'h027E);
      // Brown-out and clear in one cycle: the set must win
      clr = 1'b1;
      bo  = 1'b1;
      e(13'h0800);
      clr = 1'b0;
      bo  = 1'b0;
      e(13'h0A7E);
      $display("test brownout done");
      stop_test();
   end

   // Whole run is about forty cycles; limit allows 5000
   initial
   begin
      #100000;
      mismatches++;
      stop_test();
   end
endmodule
